// File: pkg/scan_start_pkg.sv
// constants and carrier types of the scan-start sequencer
// How it works
// - configuration bus packs byte-wide registers side by side, one strobe each
// - start write drops receiver-run at once, stopping diode and phase switching
// - receiver queue empties within one cycle of receiver-run falling, then refills
// - acquisition-run drops too; later integrations are discarded until it rises
// - start write copies all configuration registers into a holding bank
// - held bytes are combined into multi-byte configuration outputs
// - every start request increments the scan sequence number, even if superseded
// - a new start while a synchronised start is pending restarts the procedure
// - with sync set, a latch raises time-sync at next one-second pulse rising edge
// - with sync clear, time-sync is raised at once
// - wait a few cycles after start before sampling idle and time-sync
// - receiver-run rises only when idle and time-sync are both high
// - receiver-run rising starts the round-trip countdown in clock cycles
// - countdown reaching zero raises acquisition-run
// - identical scan sequencers keep receiver ticks one round-trip ahead
// - block supplies the gateway a minimum spacing between host interrupts
// - both run outputs go low on the first edge after the start strobe
// - once raised, receiver-run ignores idle until the next start write
// - firmware reset clears the scan sequence number to zero
package scan_start_pkg;

  // ****************************************************************
  // register layout on the configuration bus
  // ****************************************************************
  localparam int NUM_REGS        = 8;
  localparam int START_REG_IDX   = 0;   // start register
  localparam int SYNC_BIT_POS    = 0;   // sync flag inside it
  localparam int RTD_LO_IDX      = 1;   // round-trip delay, 16 bits
  localparam int RTD_HI_IDX      = 2;
  localparam int HOLDOFF_LO_IDX  = 3;   // interrupt holdoff, 16 bits
  localparam int HOLDOFF_HI_IDX  = 4;
  localparam int STATE_LEN_IDX   = 5;   // phase-switch state length
  localparam int INTEG_LEN_IDX   = 6;   // integration length
  localparam int SCAN_FLAGS_IDX  = 7;   // scan flags

  // ****************************************************************
  // timing and reset values
  // ****************************************************************
  localparam int           SETTLE_CYCLES = 4;  // dispatcher not-idle latency
  localparam logic [31:0]  SEQ_RESET     = 32'h0000_0000;
  localparam logic [15:0]  COUNT_ZERO    = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_WAIT   = 2'b10,
    ST_RUN    = 2'b11
  } seq_state_t;

  // frozen scan configuration handed to the controllers
  typedef struct packed {
    logic [15:0] round_trip;
    logic [15:0] holdoff;
    logic [7:0]  state_len;
    logic [7:0]  integ_len;
    logic [7:0]  scan_flags;
  } scan_cfg_t;

endpackage : scan_start_pkg

// File: verilog/scan_start_sequencer.sv
// scan-start sequencer: run control, configuration snapshot and scan numbering
`timescale 1ns/1ps
`default_nettype none
module scan_start_sequencer #(
  parameter int NUM_REGS = scan_start_pkg::NUM_REGS
) (
  input  wire logic                        mclk,
  input  wire logic                        rst,
  input  wire logic [NUM_REGS*8-1:0]       config_regs,
  input  wire logic [NUM_REGS-1:0]         config_attn,
  input  wire logic                        one_second_pulse,
  input  wire logic                        dispatch_idle,
  output logic                             rx_run,
  output logic                             acq_run,
  output logic                             rx_queue_clear,
  output scan_start_pkg::scan_cfg_t        scan_cfg,
  output logic [31:0]                      scan_sequence_number,
  output logic [15:0]                      irq_holdoff
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (NUM_REGS < scan_start_pkg::NUM_REGS) begin : g_chk
    $error("config bus holds fewer registers than the layout uses");
  end

  // the settle countdown is three bits wide
  if (scan_start_pkg::SETTLE_CYCLES < 1 || scan_start_pkg::SETTLE_CYCLES > 8) begin : g_chk_settle
    $error("settle count does not fit its counter");
  end

  // ****************************************************************
  // start strobe and pin conditioning
  // ****************************************************************
  logic start;
  logic sync_req;
  assign start    = config_attn[scan_start_pkg::START_REG_IDX];
  assign sync_req = config_regs[scan_start_pkg::START_REG_IDX*8 + scan_start_pkg::SYNC_BIT_POS];

  // the pulse pin is asynchronous to mclk
  logic pps_rise;
  pin_edge_detect #(
    .IDLE_LEVEL (1'b0)
  ) pps_cond (
    .mclk  (mclk),
    .rst   (rst),
    .pin   (one_second_pulse),
    .level (),
    .rise  (pps_rise)
  );

  // ****************************************************************
  // configuration snapshot
  // ****************************************************************
  // one holding byte per register, all loaded by the start strobe
  logic [NUM_REGS*8-1:0] held_r;
  for (genvar g = 0; g < NUM_REGS; g++) begin : g_hold
    hold_reg #(
      .WIDTH (8)
    ) bank (
      .mclk (mclk),
      .rst  (rst),
      .load (start),
      .d    (config_regs[g*8 +: 8]),
      .q    (held_r[g*8 +: 8])
    );
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      scan_cfg <= '0;
    end else begin
      // byte registers joined into wider fields
      scan_cfg.round_trip <= {held_r[scan_start_pkg::RTD_HI_IDX*8 +: 8],
                              held_r[scan_start_pkg::RTD_LO_IDX*8 +: 8]};
      scan_cfg.holdoff    <= {held_r[scan_start_pkg::HOLDOFF_HI_IDX*8 +: 8],
                              held_r[scan_start_pkg::HOLDOFF_LO_IDX*8 +: 8]};
      scan_cfg.state_len  <= held_r[scan_start_pkg::STATE_LEN_IDX*8 +: 8];
      scan_cfg.integ_len  <= held_r[scan_start_pkg::INTEG_LEN_IDX*8 +: 8];
      scan_cfg.scan_flags <= held_r[scan_start_pkg::SCAN_FLAGS_IDX*8 +: 8];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_holdoff <= scan_start_pkg::COUNT_ZERO;
    end else begin
      // holdoff follows the live register so the gateway sees changes at once
      irq_holdoff <= {config_regs[scan_start_pkg::HOLDOFF_HI_IDX*8 +: 8],
                      config_regs[scan_start_pkg::HOLDOFF_LO_IDX*8 +: 8]};
    end
  end

  // ****************************************************************
  // scan sequence number
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (rst) begin
      scan_sequence_number <= scan_start_pkg::SEQ_RESET;
    end else if (start) begin
      scan_sequence_number <= scan_sequence_number + 32'h0000_0001;
    end
  end

  // ****************************************************************
  // time-sync latch
  // ****************************************************************
  logic time_sync_r;
  logic sync_armed_r;
  always_ff @(posedge mclk) begin
    if (rst) begin
      time_sync_r  <= 1'b0;
      sync_armed_r <= 1'b0;
    end else if (start) begin
      time_sync_r  <= !sync_req;
      sync_armed_r <= sync_req;
    end else if (sync_armed_r && pps_rise) begin
      time_sync_r  <= 1'b1;
      sync_armed_r <= 1'b0;
    end
  end

  // ****************************************************************
  // run sequencing
  // ****************************************************************
  localparam logic [2:0] SETTLE_LOAD = 3'(scan_start_pkg::SETTLE_CYCLES - 1);

  scan_start_pkg::seq_state_t state_r;
  logic                       settle_zero;
  logic                       run_go;
  logic [15:0]                rtd_r;

  assign run_go = (state_r == scan_start_pkg::ST_WAIT) && dispatch_idle && time_sync_r;

  // the dispatcher reports busy only after a delay, so idle is not trusted at once
  load_down_counter #(
    .WIDTH (3)
  ) settle_cnt (
    .mclk       (mclk),
    .rst        (rst),
    .load       (start),
    .load_value (SETTLE_LOAD),
    .step       (state_r == scan_start_pkg::ST_SETTLE),
    .count      (),
    .zero       (settle_zero)
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= scan_start_pkg::ST_IDLE;
    end else if (start) begin
      // a fresh strobe restarts everything, even mid-wait
      state_r <= scan_start_pkg::ST_SETTLE;
    end else begin
      case (state_r)
        scan_start_pkg::ST_SETTLE: begin
          if (settle_zero) begin
            state_r <= scan_start_pkg::ST_WAIT;
          end
        end
        scan_start_pkg::ST_WAIT: begin
          if (run_go) begin
            state_r <= scan_start_pkg::ST_RUN;
          end
        end
        scan_start_pkg::ST_RUN: begin
          state_r <= scan_start_pkg::ST_RUN;
        end
        default: begin
          state_r <= scan_start_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_run <= 1'b0;
    end else if (start) begin
      rx_run <= 1'b0;
    end else if (state_r == scan_start_pkg::ST_WAIT && dispatch_idle && time_sync_r) begin
      rx_run <= 1'b1;
    end
  end

  // the queue clear pulses in the same cycle receiver-run falls
  always_ff @(posedge mclk) begin
    if (rst) begin
      rx_queue_clear <= 1'b0;
    end else begin
      rx_queue_clear <= start;
    end
  end

  // countdown starts from the frozen round-trip value as receiver-run rises
  load_down_counter #(
    .WIDTH (16)
  ) rtd_cnt (
    .mclk       (mclk),
    .rst        (rst),
    .load       (run_go),
    .load_value (scan_cfg.round_trip),
    .step       (rx_run),
    .count      (rtd_r),
    .zero       ()
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      acq_run <= 1'b0;
    end else if (start) begin
      acq_run <= 1'b0;
    end else if (rx_run && rtd_r == scan_start_pkg::COUNT_ZERO) begin
      acq_run <= 1'b1;
    end
  end

endmodule : scan_start_sequencer

// ****************************************************************
// pin conditioner: three stages, a change counts once two and three agree
// ****************************************************************
module pin_edge_detect #(
  parameter logic IDLE_LEVEL = 1'b0
) (
  input  wire logic mclk,
  input  wire logic rst,
  input  wire logic pin,
  output logic      level,
  output logic      rise
);

  logic [2:0] stage_r;
  logic       level_r;
  logic       agree;

  // reset to the idle level so that no false edge follows reset
  always_ff @(posedge mclk) begin
    if (rst) begin
      stage_r <= {3{IDLE_LEVEL}};
    end else begin
      stage_r <= {stage_r[1:0], pin};
    end
  end

  // only the second stage reads the first; a lone glitch is never seen
  assign agree = (stage_r[1] == stage_r[2]);

  always_ff @(posedge mclk) begin
    if (rst) begin
      level_r <= IDLE_LEVEL;
    end else if (agree) begin
      level_r <= stage_r[2];
    end
  end

  assign level = level_r;
  assign rise  = agree && stage_r[2] && !level_r;

endmodule : pin_edge_detect

// ****************************************************************
// register with a load enable
// ****************************************************************
module hold_reg #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  if (WIDTH < 1) begin : g_chk
    $error("holding register needs at least one bit");
  end

  logic [WIDTH-1:0] q_r;

  always_ff @(posedge mclk) begin
    if (rst) begin
      q_r <= '0;
    end else if (load) begin
      q_r <= d;
    end
  end

  assign q = q_r;

endmodule : hold_reg

// ****************************************************************
// loadable down-counter that parks at zero
// ****************************************************************
module load_down_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  input  wire logic             step,
  output logic      [WIDTH-1:0] count,
  output logic                  zero
);

  if (WIDTH < 1) begin : g_chk
    $error("counter needs at least one bit");
  end

  logic [WIDTH-1:0] count_r;

  // load wins over step so a restart never sees a stale count
  always_ff @(posedge mclk) begin
    if (rst) begin
      count_r <= '0;
    end else if (load) begin
      count_r <= load_value;
    end else if (step && count_r != '0) begin
      count_r <= count_r - WIDTH'(1);
    end
  end

  assign count = count_r;
  assign zero  = (count_r == '0);

endmodule : load_down_counter
`default_nettype wire

// File: verification/dispatch_model.sv
// dispatcher model: stays busy for a while after each acquisition-run change
`timescale 1ns/1ps
`default_nettype none
module dispatch_model (
  input  wire logic       mclk,
  input  wire logic       rst,
  input  wire logic       acq_run,
  input  wire logic [7:0] busy_len,
  output logic            dispatch_idle
);
  logic [7:0] left_r;
  logic       acq_q_r;
  // a halt lets the last integration finish; a start begins a new frame
  always_ff @(posedge mclk) begin
    acq_q_r <= acq_run;
    if (rst)
      left_r <= 8'h00;
    else if (acq_run != acq_q_r)
      left_r <= busy_len;
    else if (left_r != 8'h00)
      left_r <= left_r - 8'h01;
  end
  assign dispatch_idle = (left_r == 8'h00);
endmodule : dispatch_model
`default_nettype wire

// File: verification/scan_start_monitor.sv
// assertion checker on the scan-start sequencer ports
`timescale 1ns/1ps
`default_nettype none
module scan_start_monitor #(
  parameter int NUM_REGS = 8
) (
  input wire logic                      mclk,
  input wire logic                      rst,
  input wire logic [NUM_REGS*8-1:0]     config_regs,
  input wire logic [NUM_REGS-1:0]       config_attn,
  input wire logic                      dispatch_idle,
  input wire logic                      rx_run,
  input wire logic                      acq_run,
  input wire logic                      rx_queue_clear,
  input wire scan_start_pkg::scan_cfg_t scan_cfg,
  input wire logic [31:0]               scan_sequence_number,
  input wire logic [15:0]               irq_holdoff
);
  logic [16:0] run_cnt_r;
  // cycles since receiver-run came up
  always_ff @(posedge mclk) begin
    if (rst || !rx_run)
      run_cnt_r <= 17'h0_0000;
    else
      run_cnt_r <= run_cnt_r + 17'h0_0001;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_runs_drop: assert property (config_attn[0] |=> !rx_run && !acq_run)
    else $error("run high after start");
  chk_seq_step: assert property (config_attn[0] |=> scan_sequence_number == $past(scan_sequence_number) + 32'h1)
    else $error("number not stepped");
  chk_queue_clear: assert property (config_attn[0] |=> rx_queue_clear)
    else $error("no queue clear");
  chk_snap_cfg: assert property (config_attn[0] |=> ##2 scan_cfg == $past({config_regs[23:8],
    config_regs[39:24], config_regs[47:40], config_regs[55:48], config_regs[63:56]}, 3))
    else $error("bad snapshot");
  chk_settle_wait: assert property (config_attn[0] |=> !rx_run [*4])
    else $error("no settle wait");
  chk_rx_idle: assert property ($rose(rx_run) |-> $past(dispatch_idle))
    else $error("run while busy");
  chk_rx_hold: assert property (rx_run && !config_attn[0] |=> rx_run)
    else $error("run dropped");
  chk_acq_delay: assert property ($rose(acq_run) |-> run_cnt_r == {1'b0, scan_cfg.round_trip} + 17'h0_0001)
    else $error("bad round trip");
  chk_holdoff_live: assert property (1'b1 |=> irq_holdoff == $past(config_regs[39:24]))
    else $error("bad holdoff");
endmodule : scan_start_monitor
`default_nettype wire

// File: verification/test_scan_start_sequencer.sv
// testbench of the scan-start sequencer
`timescale 1ns/1ps
`default_nettype none
module test_scan_start_sequencer;
  logic                      mclk = 1'b0, rst = 1'b1, one_second_pulse = 1'b0;
  logic [63:0]               config_regs = 64'h0000_0000_0000_0000;
  logic [7:0]                config_attn = 8'h00, busy_len = 8'h00;
  logic                      dispatch_idle, rx_run, acq_run, rx_queue_clear;
  logic [31:0]               scan_sequence_number, exp_seq = 32'h0;
  logic [15:0]               irq_holdoff;
  scan_start_pkg::scan_cfg_t scan_cfg;
  int                        bad_count = 0, total_checks = 0, cycles = 0, c;
  always #2.5 mclk = ~mclk;
  scan_start_sequencer dut (.mclk(mclk), .rst(rst), .config_regs(config_regs), .config_attn(config_attn),
    .one_second_pulse(one_second_pulse), .dispatch_idle(dispatch_idle), .rx_run(rx_run), .acq_run(acq_run),
    .rx_queue_clear(rx_queue_clear), .scan_cfg(scan_cfg), .scan_sequence_number(scan_sequence_number),
    .irq_holdoff(irq_holdoff));
  dispatch_model far (.mclk(mclk), .rst(rst), .acq_run(acq_run), .busy_len(busy_len), .dispatch_idle(dispatch_idle));
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk
  // one-cycle strobe per register write, as the gateway gives it
  task automatic wr(input int idx, input logic [7:0] val);
    @(negedge mclk);
    config_regs[idx*8 +: 8] = val;
    config_attn[idx] = 1'b1;
    if (idx == 0)
      exp_seq++;
    @(negedge mclk);
    config_attn = 8'h00;
  endtask : wr
  task automatic wait_run(input bit acq);
    c = 0;
    while ((acq ? acq_run : rx_run) !== 1'b1 && c < 300) begin
      @(negedge mclk);
      c++;
    end
  endtask : wait_run
  task automatic report_and_stop;
    $display("checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      bad_count++;
      report_and_stop();
    end
  end
  task automatic t_reset;
    chk("rx_run", 1'b0, rx_run);
    chk("acq_run", 1'b0, acq_run);
    chk("number", 32'h0, scan_sequence_number);
    $display("reset test done");
  endtask : t_reset
  task automatic t_plain;
    for (int i = 1; i < 8; i++)
      wr(i, 8'(64'h0F02_0301_4000_0500 >> (i * 8)));
    wr(0, 8'h00);
    chk("run pair", 2'b00, {rx_run, acq_run});
    chk("queue clear", 1'b1, rx_queue_clear);
    chk("number", exp_seq, scan_sequence_number);
    wait_run(0);
    wait_run(1);
    chk("round trip", 32'd6, c);
    chk("cfg", 56'h00_0501_4003_020F, scan_cfg);
    chk("holdoff", 16'h0140, irq_holdoff);
    $display("plain test done");
  endtask : t_plain
  task automatic t_freeze;
    wr(1, 8'h09);
    wr(3, 8'h22);
    @(negedge mclk);
    chk("frozen trip", 16'h0005, scan_cfg.round_trip);
    chk("holdoff", 16'h0122, irq_holdoff);
    chk("rx_run", 1'b1, rx_run);
    $display("freeze test done");
  endtask : t_freeze
  task automatic t_idle;
    busy_len = 8'd20;
    wr(0, 8'h00);
    wait_run(0);
    chk("idle wait", 1'b1, c > 15);
    wait_run(1);
    chk("round trip", 32'd10, c);
    repeat (25) @(negedge mclk);
    chk("rx_run", 1'b1, rx_run);
    busy_len = 8'd0;
    $display("idle test done");
  endtask : t_idle
  task automatic t_sync;
    wr(0, 8'h01);
    repeat (20) @(negedge mclk);
    chk("rx_run", 1'b0, rx_run);
    one_second_pulse = 1'b1;
    wait_run(0);
    chk("sync start", 1'b1, c < 10);
    one_second_pulse = 1'b0;
    $display("sync test done");
  endtask : t_sync
  task automatic t_super;
    wr(0, 8'h01);
    wr(0, 8'h00);
    wait_run(0);
    chk("restart", 1'b1, c < 20);
    chk("number", exp_seq, scan_sequence_number);
    $display("supersede test done");
  endtask : t_super
  initial begin
    repeat (10) @(negedge mclk);
    rst = 1'b0;
    t_reset();
    t_plain();
    t_freeze();
    t_idle();
    t_sync();
    t_super();
    report_and_stop();
  end
endmodule : test_scan_start_sequencer
bind scan_start_sequencer scan_start_monitor #(.NUM_REGS(NUM_REGS)) mon (.mclk(mclk), .rst(rst),
  .config_regs(config_regs), .config_attn(config_attn), .dispatch_idle(dispatch_idle), .rx_run(rx_run),
  .acq_run(acq_run), .rx_queue_clear(rx_queue_clear), .scan_cfg(scan_cfg),
  .scan_sequence_number(scan_sequence_number), .irq_holdoff(irq_holdoff));
`default_nettype wire
